/* rtl/cbrs_consts.vh */
// Contract
// - Two sets of eight thermistors with count sixteen give sixteen consecutive identifiers.
// - Every read position takes an identifier; absent positions send nothing and leave gaps.
// - The second set's first position follows the first set's last identifier directly.
// - Enable address equal to value address, count one: send only when value reads one.
// - The serial-line slave node address comes from a writable setting.
// - Stride is added to both value and enable addresses between successive reads.
// - Slot zero starts at first identifier plus 64; later slots follow by count.
// - Each position reads its enable register and sends only when it shows enabled.
// - A slot whose value base address is zero sends no messages.
`ifndef CBRS_CONSTS_VH
`define CBRS_CONSTS_VH

// Register byte addresses
`define CBRS_ADDR_CTRL 8'h00
`define CBRS_ADDR_ID_BASE 8'h04
`define CBRS_ADDR_NODE 8'h08
`define CBRS_ADDR_STATUS 8'h0c
`define CBRS_SLOT_FIRST 4'h1
`define CBRS_SLOT_LAST 4'h4

// Word index of each field inside a slot's 16-byte window
`define CBRS_FLD_VBASE 2'h0
`define CBRS_FLD_EBASE 2'h1
`define CBRS_FLD_STRIDE 2'h2
`define CBRS_FLD_COUNT 2'h3

// Field positions
`define CBRS_CTRL_RUN_BIT 0
`define CBRS_EN_BIT 0
`define CBRS_STAT_BUSY_BIT 0
`define CBRS_STAT_SLOT_LSB 4
`define CBRS_STAT_SENT_LSB 16

// Reset values
`define CBRS_RST_RUN 1'b0
`define CBRS_RST_ID_BASE 11'h100
`define CBRS_RST_NODE 8'h01
`define CBRS_RST_FIELD 16'h0000

// First slot identifier sits this far above the configured first identifier
`define CBRS_ID_SLOT_OFFSET 11'h040
`define CBRS_LAST_SLOT 2'h3

// Timing
`define CBRS_INTERVAL_US 500000
`define CBRS_CLK_MHZ 50

`endif

/* rtl/cbrs_avalon_regs.v */
`timescale 1ns/1ps
`include "cbrs_consts.vh"

module cbrs_avalon_regs (
   // Clock and reset
   input wire i_clock,
   input wire i_reset_n,
   // Avalon-MM slave
   input wire [7:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // Configuration out
   output wire o_run,
   output wire [10:0] o_id_base,
   output wire [7:0] o_node_addr,
   output wire [63:0] o_value_base,
   output wire [63:0] o_enable_base,
   output wire [63:0] o_stride,
   output wire [63:0] o_count,
   // Status in
   input wire i_busy,
   input wire [1:0] i_slot,
   input wire [15:0] i_sent_count
);

   reg ack_reg;
   reg run_reg;
   reg [10:0] id_base_reg;
   reg [7:0] node_reg;
   reg [15:0] field_reg [0:15];
   wire req;
   wire wr_now;
   integer k;

   // Returns {hit, slot, field} for a slot window address
   function [4:0] slot_decode;
      input [7:0] a;
      begin
         slot_decode[4] = (a[7:4] >= `CBRS_SLOT_FIRST) && (a[7:4] <= `CBRS_SLOT_LAST);
         slot_decode[3:2] = a[5:4] - 2'h1;
         slot_decode[1:0] = a[3:2];
      end
   endfunction

   wire [4:0] dec = slot_decode(i_avs_address);
   wire [3:0] fidx = dec[3:0];

   // One wait state on every access; the answer is known one edge after the request
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_reg;
   assign wr_now = i_avs_write & ack_reg;

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_reg <= 1'b0;
         o_avs_readdata <= 32'h00000000;
         run_reg <= `CBRS_RST_RUN;
         id_base_reg <= `CBRS_RST_ID_BASE;
         node_reg <= `CBRS_RST_NODE;
         for (k = 0; k < 16; k = k + 1) begin
            field_reg[k] <= `CBRS_RST_FIELD;
         end
      end else begin
         ack_reg <= req & ~ack_reg;
         if (i_avs_read && !ack_reg) begin
            o_avs_readdata <= 32'h00000000;
            if (dec[4]) begin
               o_avs_readdata <= {16'h0000, field_reg[fidx]};
            end else begin
               case (i_avs_address & 8'hfc)
                  `CBRS_ADDR_CTRL: o_avs_readdata[`CBRS_CTRL_RUN_BIT] <= run_reg;
                  `CBRS_ADDR_ID_BASE: o_avs_readdata <= {21'h000000, id_base_reg};
                  `CBRS_ADDR_NODE: o_avs_readdata <= {24'h000000, node_reg};
                  `CBRS_ADDR_STATUS: begin
                     o_avs_readdata[`CBRS_STAT_BUSY_BIT] <= i_busy;
                     o_avs_readdata[`CBRS_STAT_SLOT_LSB +: 2] <= i_slot;
                     o_avs_readdata[`CBRS_STAT_SENT_LSB +: 16] <= i_sent_count;
                  end
                  default: o_avs_readdata <= 32'h00000000;
               endcase
            end
         end
         if (wr_now) begin
            if (dec[4]) begin
               field_reg[fidx] <= i_avs_writedata[15:0];
            end else begin
               case (i_avs_address & 8'hfc)
                  `CBRS_ADDR_CTRL: run_reg <= i_avs_writedata[`CBRS_CTRL_RUN_BIT];
                  `CBRS_ADDR_ID_BASE: id_base_reg <= i_avs_writedata[10:0];
                  `CBRS_ADDR_NODE: node_reg <= i_avs_writedata[7:0];
                  default: run_reg <= run_reg;
               endcase
            end
         end
      end
   end

   assign o_run = run_reg;
   assign o_id_base = id_base_reg;
   assign o_node_addr = node_reg;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_slot
         assign o_value_base[g*16 +: 16] = field_reg[g*4 + `CBRS_FLD_VBASE];
         assign o_enable_base[g*16 +: 16] = field_reg[g*4 + `CBRS_FLD_EBASE];
         assign o_stride[g*16 +: 16] = field_reg[g*4 + `CBRS_FLD_STRIDE];
         assign o_count[g*16 +: 16] = field_reg[g*4 + `CBRS_FLD_COUNT];
      end
   endgenerate

endmodule

/* rtl/cbrs_sequencer.v */
`timescale 1ns/1ps
`include "cbrs_consts.vh"

module cbrs_sequencer #(
   parameter [31:0] INTERVAL_CYCLES = `CBRS_INTERVAL_US * `CBRS_CLK_MHZ
) (
   // Clock and reset
   input wire i_clock,
   input wire i_reset_n,
   // Avalon-MM slave
   input wire [7:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output wire [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // Internal register read port
   output wire o_rd_req,
   output reg [15:0] o_rd_addr,
   input wire i_rd_ack,
   input wire [15:0] i_rd_data,
   // Outgoing broadcast messages
   output wire o_msg_valid,
   output reg [10:0] o_msg_id,
   output reg [15:0] o_msg_data,
   input wire i_msg_ready,
   // Serial-line slave node address
   output wire [7:0] o_node_addr
);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_SLOT = 7'h02;
   localparam [6:0] S_RD_EN = 7'h04;
   localparam [6:0] S_RD_VAL = 7'h08;
   localparam [6:0] S_SEND = 7'h10;
   localparam [6:0] S_ADV = 7'h20;
   localparam [6:0] S_NEXT = 7'h40;

   wire run;
   wire [10:0] id_base;
   wire [63:0] value_base;
   wire [63:0] enable_base;
   wire [63:0] stride;
   wire [63:0] count;

   reg [6:0] state_reg;
   reg [31:0] timer_reg;
   reg [1:0] slot_reg;
   reg [10:0] id_reg;
   reg [15:0] pos_reg;
   reg [15:0] count_reg;
   reg [15:0] stride_reg;
   reg [15:0] vaddr_reg;
   reg [15:0] eaddr_reg;
   reg [15:0] sent_reg;
   reg [31:0] timer_next;
   wire pass_start;
   wire last_pos;
   wire slot_off;

   // Picks one slot's 16-bit field out of the flattened four-slot buses
   function [15:0] slot_field;
      input [63:0] flat;
      input [1:0] s;
      begin
         slot_field = flat[s*16 +: 16];
      end
   endfunction

   wire [15:0] slot_vbase = slot_field(value_base, slot_reg);
   wire [15:0] slot_ebase = slot_field(enable_base, slot_reg);
   wire [15:0] slot_stride = slot_field(stride, slot_reg);
   wire [15:0] slot_count = slot_field(count, slot_reg);

   cbrs_avalon_regs u_regs (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest),
      .o_run(run),
      .o_id_base(id_base),
      .o_node_addr(o_node_addr),
      .o_value_base(value_base),
      .o_enable_base(enable_base),
      .o_stride(stride),
      .o_count(count),
      .i_busy(~state_reg[0]),
      .i_slot(slot_reg),
      .i_sent_count(sent_reg)
   );

   assign o_rd_req = state_reg[2] | state_reg[3];
   assign o_msg_valid = state_reg[4];
   // A pass starts only from idle, once the previous interval has run out
   assign pass_start = (state_reg == S_IDLE) && run && (timer_reg == 32'h00000000);
   // Last position of the slot when the next index reaches the latched count
   assign last_pos = (pos_reg + 16'h0001) == count_reg;
   // A zero base or zero count silences the slot, yet its identifiers stay reserved
   assign slot_off = (slot_vbase == 16'h0000) || (slot_count == 16'h0000);

   // Interval timer keeps counting during a pass; an overrunning pass starts the next one at once
   always @* begin
      timer_next = timer_reg;
      if (pass_start) begin
         timer_next = INTERVAL_CYCLES - 32'h00000001;
      end else if (timer_reg != 32'h00000000) begin
         timer_next = timer_reg - 32'h00000001;
      end
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         timer_reg <= 32'h00000000;
      end else begin
         timer_reg <= timer_next;
      end
   end

   // Message registers load only on the value answer, so they stand while the consumer stalls
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_msg_id <= 11'h000;
         o_msg_data <= 16'h0000;
      end else if (state_reg == S_RD_VAL && i_rd_ack) begin
         o_msg_data <= i_rd_data;
         o_msg_id <= id_reg;
      end
   end

   // Accepted messages for the status word; the count wraps silently
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sent_reg <= 16'h0000;
      end else if (o_msg_valid && i_msg_ready) begin
         sent_reg <= sent_reg + 16'h0001;
      end
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= S_IDLE;
         slot_reg <= 2'h0;
         id_reg <= 11'h000;
         pos_reg <= 16'h0000;
         count_reg <= 16'h0000;
         stride_reg <= 16'h0000;
         vaddr_reg <= 16'h0000;
         eaddr_reg <= 16'h0000;
         o_rd_addr <= 16'h0000;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (pass_start) begin
                  slot_reg <= 2'h0;
                  id_reg <= id_base + `CBRS_ID_SLOT_OFFSET;
                  state_reg <= S_SLOT;
               end
            end
            S_SLOT: begin
               // Count and stride are latched so a write mid-slot cannot tear the walk
               pos_reg <= 16'h0000;
               count_reg <= slot_count;
               stride_reg <= slot_stride;
               vaddr_reg <= slot_vbase;
               eaddr_reg <= slot_ebase;
               o_rd_addr <= slot_ebase;
               if (slot_off) begin
                  // Identifiers still advance by count so later slots keep their place
                  id_reg <= id_reg + slot_count[10:0];
                  state_reg <= S_NEXT;
               end else begin
                  state_reg <= S_RD_EN;
               end
            end
            S_RD_EN: begin
               if (i_rd_ack) begin
                  o_rd_addr <= vaddr_reg;
                  if (i_rd_data[`CBRS_EN_BIT]) begin
                     state_reg <= S_RD_VAL;
                  end else begin
                     state_reg <= S_ADV;
                  end
               end
            end
            S_RD_VAL: begin
               if (i_rd_ack) begin
                  state_reg <= S_SEND;
               end
            end
            S_SEND: begin
               if (i_msg_ready) begin
                  state_reg <= S_ADV;
               end
            end
            S_ADV: begin
               // Every position consumes an identifier, sent or not
               id_reg <= id_reg + 11'h001;
               pos_reg <= pos_reg + 16'h0001;
               vaddr_reg <= vaddr_reg + stride_reg;
               eaddr_reg <= eaddr_reg + stride_reg;
               o_rd_addr <= eaddr_reg + stride_reg;
               if (last_pos) begin
                  state_reg <= S_NEXT;
               end else begin
                  state_reg <= S_RD_EN;
               end
            end
            S_NEXT: begin
               if (slot_reg == `CBRS_LAST_SLOT) begin
                  state_reg <= S_IDLE;
               end else begin
                  slot_reg <= slot_reg + 2'h1;
                  state_reg <= S_SLOT;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule

/* tb/cbrs_sequencer_assertions.sv */
`timescale 1ns/1ps
module cbrs_checker #(
   parameter [31:0] INTERVAL_CYCLES = 200
) (
   input wire i_clock,
   input wire i_reset_n,
   input wire [7:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire o_avs_waitrequest,
   input wire o_rd_req,
   input wire [15:0] o_rd_addr,
   input wire i_rd_ack,
   input wire [15:0] i_rd_data,
   input wire o_msg_valid,
   input wire [10:0] o_msg_id,
   input wire [15:0] o_msg_data,
   input wire i_msg_ready,
   input wire [7:0] o_node_addr
);
   // High while the next answered read is a value read
   reg ph_reg;
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n)
         ph_reg <= 1'b0;
      else if (o_rd_req && i_rd_ack)
         ph_reg <= !ph_reg && i_rd_data[0];
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   sequence en_on; o_rd_req && i_rd_ack && !ph_reg && i_rd_data[0]; endsequence
   sequence en_off; o_rd_req && i_rd_ack && !ph_reg && !i_rd_data[0]; endsequence
   sequence val_rd; o_rd_req && i_rd_ack && ph_reg; endsequence
   sequence taken; o_msg_valid && i_msg_ready; endsequence
   one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer late");
   idle_wait_a: assert property (!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
      else $error("wait without request");
   rd_hold_a: assert property (o_rd_req && !i_rd_ack |=> o_rd_req && $stable(o_rd_addr))
      else $error("read request dropped");
   msg_hold_a: assert property (o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable({o_msg_id, o_msg_data}))
      else $error("message changed while stalled");
   msg_gap_a: assert property (taken |=> !o_msg_valid && !o_rd_req)
      else $error("no gap after message");
   node_wr_a: assert property (i_avs_write && !o_avs_waitrequest && i_avs_address[7:2] == 6'h02
      |=> o_node_addr == $past(i_avs_writedata[7:0])) else $error("node address not taken");
   en_off_a: assert property (en_off |=> !o_msg_valid [*3])
      else $error("message from disabled position");
   val_next_a: assert property (en_on |=> o_rd_req)
      else $error("value read missing");
   msg_data_a: assert property (val_rd |=> o_msg_valid && o_msg_data == $past(i_rd_data))
      else $error("message data wrong");
endmodule
bind cbrs_sequencer cbrs_checker #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) u_chk (.i_clock(i_clock),
   .i_reset_n(i_reset_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest), .o_rd_req(o_rd_req),
   .o_rd_addr(o_rd_addr), .i_rd_ack(i_rd_ack), .i_rd_data(i_rd_data), .o_msg_valid(o_msg_valid),
   .o_msg_id(o_msg_id), .o_msg_data(o_msg_data), .i_msg_ready(i_msg_ready), .o_node_addr(o_node_addr));

/* tb/cbrs_regspace_model.sv */
`timescale 1ns/1ps
module cbrs_regspace_model (
   input wire i_clock,
   input wire i_reset_n,
   input wire i_rd_req,
   input wire [15:0] i_rd_addr,
   input wire i_gpi,
   output reg o_rd_ack,
   output reg [15:0] o_rd_data
);
   reg [1:0] cnt_reg;
   function [15:0] look(input [15:0] a);
      case (a[15:12])
         4'h2: look = {15'h0000, a[3:0] < 4'hc};
         4'h4: look = 16'h0001;
         4'h5: look = {15'h0000, i_gpi};
         default: look = a;
      endcase
   endfunction
   // Delay set by address bits, so both prompt and slow answers occur
   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rd_ack <= 1'b0;
         cnt_reg <= 2'h0;
         o_rd_data <= 16'hffff;
      end else if (i_rd_req && !o_rd_ack && cnt_reg == i_rd_addr[1:0]) begin
         o_rd_ack <= 1'b1;
         o_rd_data <= look(i_rd_addr);
         cnt_reg <= 2'h0;
      end else begin
         o_rd_ack <= 1'b0;
         // Data is not held past the answer
         o_rd_data <= ~o_rd_data;
         if (i_rd_req && !o_rd_ack)
            cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule

/* tb/cbrs_sequencer_tb.sv */
`timescale 1ns/1ps
module cbrs_sequencer_tb;
   reg i_clock = 1'b0;
   reg i_reset_n = 1'b0;
   reg [7:0] i_avs_address = 8'h00;
   reg i_avs_read = 1'b0;
   reg i_avs_write = 1'b0;
   reg [31:0] i_avs_writedata = 32'h0;
   reg i_msg_ready = 1'b0;
   reg gpi = 1'b0;
   wire [31:0] o_avs_readdata;
   wire o_avs_waitrequest, o_rd_req, i_rd_ack, o_msg_valid;
   wire [15:0] o_rd_addr, i_rd_data, o_msg_data;
   wire [10:0] o_msg_id;
   wire [7:0] o_node_addr;
   integer miscompares = 0;
   integer n_checks = 0;
   integer mi = 0;
   integer passes = 0;
   integer total = 0;
   reg [10:0] idb;
   reg [31:0] rd;
   reg [26:0] eq[$];
   reg [15:0] cfg[16] = '{16'h1000, 16'h2000, 1, 32, 16'h3000, 16'h4000, 3, 16, 0, 0, 0, 5, 16'h5000, 16'h5000, 0, 1};
   always #10 i_clock = ~i_clock;
   cbrs_sequencer #(.INTERVAL_CYCLES(200)) u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_ack(i_rd_ack), .i_rd_data(i_rd_data),
      .o_msg_valid(o_msg_valid), .o_msg_id(o_msg_id), .o_msg_data(o_msg_data), .i_msg_ready(i_msg_ready),
      .o_node_addr(o_node_addr));
   cbrs_regspace_model u_regs (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_rd_req(o_rd_req),
      .i_rd_addr(o_rd_addr), .i_gpi(gpi), .o_rd_ack(i_rd_ack), .o_rd_data(i_rd_data));
   task check(input string name, input [31:0] seen, input [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      integer n;
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_writedata <= d;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      check("bus wait", n, 2);
      @(posedge i_clock);
   endtask
   function void build(input g);
      reg [10:0] id;
      eq.delete();
      id = idb + 11'h040;
      for (int k = 0; k < 32; k++)
         if (k % 16 < 12) eq.push_back({id + k[10:0], 16'h1000 + k[15:0]});
      id = id + 11'd32;
      for (int k = 0; k < 16; k++)
         eq.push_back({id + k[10:0], 16'h3000 + 16'd3 * k[15:0]});
      id = id + 11'd21;
      if (g) eq.push_back({id, 16'h0001});
   endfunction
   task stop_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge i_clock) i_msg_ready <= ($urandom % 4) != 0;
   // Condition input flips only at a pass start, well before slot three reads it
   always @(posedge i_clock) begin
      if (i_reset_n && o_msg_valid && i_msg_ready) begin
         if (mi == 0) begin
            gpi <= passes[0];
            build(passes[0]);
         end
         check("msg", {o_msg_id, o_msg_data}, eq[mi]);
         total++;
         mi++;
         if (mi == eq.size()) begin
            mi = 0;
            passes++;
            $display("pass %0d checked", passes);
         end
      end
   end
   initial begin
      #400000;
      miscompares++;
      stop_test;
   end
   initial begin
      rd = $urandom(32'hf68a);
      repeat (2) @(posedge i_clock);
      i_reset_n <= 1'b1;
      @(posedge i_clock);
      bus(0, 8'h04, 0);
      check("first id", rd, 32'h100);
      bus(0, 8'h08, 0);
      check("node", rd, 32'h1);
      bus(0, 8'hfc, 0);
      check("unmapped", rd, 0);
      idb = 11'($urandom);
      bus(1, 8'h08, {24'h0, idb[7:0]});
      check("node out", o_node_addr, idb[7:0]);
      bus(0, 8'h08, 0);
      check("node read", rd, idb[7:0]);
      $display("register test done");
      bus(1, 8'h04, {21'h0, idb});
      // Cell span 32 with gaps, thermistors 16, slot two off, slot three conditional
      for (int s = 0; s < 16; s++) bus(1, 8'h10 + 8'(s * 4), cfg[s]);
      bus(1, 8'h00, 1);
      for (int n = 0; n < 20000 && passes < 3; n++) @(posedge i_clock);
      check("passes", passes >= 3, 1);
      bus(1, 8'h00, 0);
      repeat (2000) @(posedge i_clock);
      check("pass end", mi, 0);
      rd = total;
      repeat (500) @(posedge i_clock);
      check("quiet", total, rd);
      bus(0, 8'h00, 0);
      check("run off", rd, 0);
      bus(0, 8'h1c, 0);
      check("slot count", rd, cfg[3]);
      bus(0, 8'h0c, 0);
      check("status", rd, {total[15:0], 16'h0030});
      $display("broadcast test done");
      stop_test;
   end
endmodule
